// ===== src/soe_cfg.svh
// Constants of the security-region erase sequencer.
// Assumes an 8-bit opcode, MSB-first serial framing.
`ifndef SOE_CFG_SVH
`define SOE_CFG_SVH
`define SOE_OP_WREN 8'h06
`define SOE_OP_WRDI 8'h04
`define SOE_OP_RDSR 8'h05
`define SOE_OP_ERASE 8'h44
`define SOE_OP_LAST 6'h07
`define SOE_OP_BITS 6'h08
`define SOE_BITS_3B 6'h20
`define SOE_BITS_4B 6'h28
`define SOE_CNT_MAX 6'h3F
`define SOE_REG1 4'h1
`define SOE_REG2 4'h2
`define SOE_REG3 4'h3
`define SOE_ERASE_TIME_US 200
`define SOE_CLK_NS 25
`define SOE_TMR_W 20
`endif

// ===== src/soe_pkg.sv
// Types shared by the security-region erase sequencer.
// Assumes soe_cfg.svh supplies the constants.
package soe_pkg;
   // Status bits as seen by a status read
   typedef struct packed {
      logic write_enable_latch;
      logic busy;
   } soe_stat_t;
   // Sequencer state
   typedef enum logic {SOE_IDLE, SOE_ERASE} soe_state_t;
endpackage

// ===== src/soe_region_erase.sv
// Security-region erase sequencer: serial opcode/address capture,
// write-enable latch, lock checks, self-timed erase and status read.
// Assumes serial pins come from outside; lock and mode bits are on clk_sys.
`timescale 1ns/1ps
`include "soe_cfg.svh"

module soe_region_erase #(
   parameter int ERASE_CYC = (`SOE_ERASE_TIME_US * 1000 + `SOE_CLK_NS - 1) / `SOE_CLK_NS
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in,
   input wire logic [2:0] region_otp_lock_bits,
   input wire logic quad_peripheral_mode,
   input wire logic addr4_mode,
   output logic serial_out_ff,
   output logic serial_out_en_ff,
   output soe_pkg::soe_stat_t status_ff,
   output logic [2:0] erase_region_ff,
   output logic erase_reject_ff
);
   import soe_pkg::*;

   // ==========================================================
   // Address decode
   // Returns a one-hot region, zero for any illegal address
   function automatic logic [2:0] region_of(input logic [31:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a[31:16] == 16'h0000 && a[11:8] == 4'h0) begin
         unique case (a[15:12])
            `SOE_REG1: r = 3'h1;
            `SOE_REG2: r = 3'h2;
            `SOE_REG3: r = 3'h4;
            default: r = 3'h0;
         endcase
      end
      return r;
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic sclk_m_ff, sclk_s_ff, sclk_d_ff;
   logic cs_m_ff, cs_s_ff, cs_d_ff;
   logic si_m_ff, si_s_ff;
   logic sclk_rise, sclk_fall, cs_rise, cs_low;

   // Two stages each; the second stage and its delayed copy feed edge logic
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sclk_m_ff <= 1'b0;
         sclk_s_ff <= 1'b0;
         sclk_d_ff <= 1'b0;
         cs_m_ff <= 1'b1;
         cs_s_ff <= 1'b1;
         cs_d_ff <= 1'b1;
         si_m_ff <= 1'b0;
         si_s_ff <= 1'b0;
      end else begin
         sclk_m_ff <= sclk;
         sclk_s_ff <= sclk_m_ff;
         sclk_d_ff <= sclk_s_ff;
         cs_m_ff <= cs_n;
         cs_s_ff <= cs_m_ff;
         cs_d_ff <= cs_s_ff;
         si_m_ff <= serial_in;
         si_s_ff <= si_m_ff;
      end
   end

   // Edge strobes, all one clk_sys cycle wide
   assign cs_low = !cs_s_ff;
   assign sclk_rise = sclk_s_ff && !sclk_d_ff && cs_low;
   assign sclk_fall = !sclk_s_ff && sclk_d_ff && cs_low;
   assign cs_rise = cs_s_ff && !cs_d_ff;

   // ==========================================================
   // Frame capture
   logic [39:0] shift_ff;
   logic [5:0] bitcnt_ff;
   logic [7:0] op_ff;

   // Bits latch on serial clock rise; count saturates so long frames stay long
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift_ff <= 40'h00_0000_0000;
         bitcnt_ff <= 6'h00;
         op_ff <= 8'h00;
      end else if (!cs_low) begin
         bitcnt_ff <= 6'h00;
      end else if (sclk_rise) begin
         shift_ff <= {shift_ff[38:0], si_s_ff};
         if (bitcnt_ff != `SOE_CNT_MAX)
            bitcnt_ff <= bitcnt_ff + 6'h01;
         if (bitcnt_ff == `SOE_OP_LAST)
            op_ff <= {shift_ff[6:0], si_s_ff};
      end
   end

   // ==========================================================
   // Frame check at chip select rise
   logic [31:0] addr;
   logic [5:0] need_bits;
   logic [2:0] sel;
   logic busy;
   logic go_erase, go_wren, go_wrdi;

   assign addr = addr4_mode ? shift_ff[31:0] : {8'h00, shift_ff[23:0]};
   assign need_bits = addr4_mode ? `SOE_BITS_4B : `SOE_BITS_3B;
   assign sel = region_of(addr);
   assign busy = status_ff.busy;

   // exact length; latch set; lock; single line; idle only
   assign go_erase = cs_rise && !busy && op_ff == `SOE_OP_ERASE && bitcnt_ff == need_bits
                     && status_ff.write_enable_latch && sel != 3'h0 && (sel & region_otp_lock_bits) == 3'h0
                     && !quad_peripheral_mode;
   assign go_wren = cs_rise && !busy && op_ff == `SOE_OP_WREN && bitcnt_ff == `SOE_OP_BITS;
   assign go_wrdi = cs_rise && !busy && op_ff == `SOE_OP_WRDI && bitcnt_ff == `SOE_OP_BITS;

   // ==========================================================
   // Erase sequencer and status
   soe_state_t state_ff;
   logic [`SOE_TMR_W-1:0] timer_ff;
   logic done;

   assign done = state_ff == SOE_ERASE && timer_ff == '0;

   // self-timed erase; one region strobe held for the whole cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_ff <= SOE_IDLE;
         timer_ff <= '0;
         erase_region_ff <= 3'h0;
      end else begin
         unique case (state_ff)
            SOE_IDLE: begin
               if (go_erase) begin
                  state_ff <= SOE_ERASE;
                  timer_ff <= `SOE_TMR_W'(ERASE_CYC - 1);
                  erase_region_ff <= sel;
               end
            end
            SOE_ERASE: begin
               if (done) begin
                  state_ff <= SOE_IDLE;
                  erase_region_ff <= 3'h0;
               end else begin
                  timer_ff <= timer_ff - `SOE_TMR_W'(1);
               end
            end
         endcase
      end
   end

   // busy follows the cycle; latch clears at completion
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         status_ff <= '0;
      end else begin
         status_ff.busy <= go_erase || (busy && !done);
         if (done || go_wrdi)
            status_ff.write_enable_latch <= 1'b0;
         else if (go_wren)
            status_ff.write_enable_latch <= 1'b1;
      end
   end

   // Pulse when an erase frame with a complete opcode is dropped, handy for debug
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         erase_reject_ff <= 1'b0;
      else
         erase_reject_ff <= cs_rise && op_ff == `SOE_OP_ERASE && bitcnt_ff >= `SOE_OP_BITS
                            && !go_erase;
   end

   // ==========================================================
   // Status read output
   logic [2:0] rd_idx_ff;
   logic [7:0] stat_byte;
   logic rd_active;

   assign stat_byte = {6'h00, status_ff.write_enable_latch, status_ff.busy};
   assign rd_active = op_ff == `SOE_OP_RDSR && bitcnt_ff >= `SOE_OP_BITS;

   // status stays readable while busy; bits shift out MSB first on fall
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_idx_ff <= 3'h0;
         serial_out_ff <= 1'b0;
         serial_out_en_ff <= 1'b0;
      end else if (!cs_low) begin
         rd_idx_ff <= 3'h0;
         serial_out_en_ff <= 1'b0;
      end else if (sclk_fall && rd_active) begin
         serial_out_ff <= stat_byte[~rd_idx_ff];
         serial_out_en_ff <= 1'b1;
         rd_idx_ff <= rd_idx_ff + 3'h1;
      end
   end

   // ==========================================================
   // Checks
   logic [`SOE_TMR_W-1:0] busy_len_ff;

   // Counts cycles of busy so the cycle length can be checked
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         busy_len_ff <= '0;
      else if (busy)
         busy_len_ff <= busy_len_ff + `SOE_TMR_W'(1);
      else
         busy_len_ff <= '0;
   end

   a_start_needs_wel: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> $past(status_ff.write_enable_latch))
      else $error("erase started without write enable");
   a_start_exact_len: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> $past(bitcnt_ff) == (addr4_mode ? `SOE_BITS_4B : `SOE_BITS_3B))
      else $error("erase started on a frame of wrong length");
   a_start_addr_ok: assert property (@(posedge clk_sys) disable iff (!nrst)
      go_erase |-> addr[31:16] == 16'h0000 && addr[11:8] == 4'h0
         && addr[15:12] >= `SOE_REG1 && addr[15:12] <= `SOE_REG3)
      else $error("erase started on illegal address");
   a_lock_blocks: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> (erase_region_ff & $past(region_otp_lock_bits)) == 3'h0)
      else $error("locked region erased");
   a_quad_blocks: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> !$past(quad_peripheral_mode))
      else $error("erase started in quad mode");
   a_one_region: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy |-> $onehot(erase_region_ff))
      else $error("erase strobe not one region");
   a_busy_length: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(busy) |-> busy_len_ff == `SOE_TMR_W'(ERASE_CYC))
      else $error("erase cycle length wrong");
   a_wel_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(busy) |-> !status_ff.write_enable_latch)
      else $error("write enable not cleared after erase");
   a_busy_ignores: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy && !done |=> $stable(status_ff.write_enable_latch) && $stable(erase_region_ff))
      else $error("instruction acted on while busy");
   a_busy_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> busy [*8])
      else $error("busy dropped early");

   // Further guards on strobes, latch, timer and read enable
   // no strobe idle
   a_idle_no_region: assert property (@(posedge clk_sys) disable iff (!nrst)
      !busy |-> erase_region_ff == 3'h0)
      else $error("region strobe outside erase");
   a_wel_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(status_ff.write_enable_latch) |-> $past(op_ff) == `SOE_OP_WREN && !$past(busy))
      else $error("write enable set without request");
   a_reject_no_start: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> !erase_reject_ff)
      else $error("erase both started and refused");
   a_timer_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
      state_ff == SOE_ERASE |-> timer_ff < `SOE_TMR_W'(ERASE_CYC))
      else $error("erase timer out of range");
   a_out_en_drops: assert property (@(posedge clk_sys) disable iff (!nrst)
      cs_s_ff |=> !serial_out_en_ff)
      else $error("read data driven while deselected");
   a_wel_falls: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(status_ff.write_enable_latch) |-> $past(done) || $past(op_ff) == `SOE_OP_WRDI)
      else $error("write enable cleared without cause");

endmodule // soe_region_erase

// ===== tb/soe_host_model.sv
// Host controller model that frames opcodes and addresses on the serial link.
// Assumes the bench calls frame() just after a falling clk_sys edge.
`timescale 1ns/1ps
// ==========================================
// Host model
module soe_host_model (
   input wire logic clk_sys,
   input wire logic serial_out_ff,
   output logic sclk,
   output logic cs_n,
   output logic serial_in,
   output logic [7:0] rd_byte
);
   // Idle link: clock stands low, select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_in = 1'b0;
      rd_byte = 8'h00;
   end
   // Four clk_sys per phase keeps above the 3-cycle minimum
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // MSB first, select rises after last bit
   task automatic frame(input logic [39:0] bits, input int n, input bit rd);
      cs_n = 1'b0;
      wt(4);
      for (int i = 0; i < n + (rd ? 8 : 0); i++) begin
         serial_in = (i < n) ? bits[39 - i] : ~serial_in;
         sclk = 1'b0;
         wt(4);
         if (i >= n) rd_byte[7 - (i - n)] = serial_out_ff;
         sclk = 1'b1;
         wt(4);
      end
      sclk = 1'b0;
      wt(1);
      // Released data line shows the inverse, never a stale bit
      cs_n = 1'b1;
      serial_in = ~serial_in;
      wt(6);
   endtask
endmodule // soe_host_model

// ===== tb/test_soe_region_erase.sv
// Self-checking bench of the region erase sequencer.
// Assumes soe_host_model drives the serial pins; mode and lock bits come from here.
`timescale 1ns/1ps
// ==========================================
// Bench top
module test_soe_region_erase;
   import soe_pkg::*;
   localparam int ERASE_CYC = 600;
   logic clk_sys = 1'b0, nrst = 1'b0, sclk, cs_n, serial_in, serial_out_ff, serial_out_en_ff, erase_reject_ff;
   logic [2:0] region_otp_lock_bits = 3'h0, erase_region_ff;
   logic quad_peripheral_mode = 1'b0, addr4_mode = 1'b0;
   logic [7:0] rd_byte;
   soe_stat_t status_ff;
   int bad_count = 0, n_compared = 0, cycles = 0, busy_len = 0, last_len = 0, rejects = 0, starts = 0;
   int en_hits = 0;
   always #12.5 clk_sys = ~clk_sys;
   soe_region_erase #(.ERASE_CYC(ERASE_CYC)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
      .serial_in(serial_in), .region_otp_lock_bits(region_otp_lock_bits),
      .quad_peripheral_mode(quad_peripheral_mode), .addr4_mode(addr4_mode), .serial_out_ff(serial_out_ff),
      .serial_out_en_ff(serial_out_en_ff), .status_ff(status_ff), .erase_region_ff(erase_region_ff),
      .erase_reject_ff(erase_reject_ff));
   soe_host_model i_host (.clk_sys(clk_sys), .serial_out_ff(serial_out_ff), .sclk(sclk), .cs_n(cs_n),
      .serial_in(serial_in), .rd_byte(rd_byte));
   // Busy length, erase starts and refusals; a hang ends the run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (erase_reject_ff === 1'b1) rejects <= rejects + 1;
      if (serial_out_en_ff === 1'b1) en_hits <= en_hits + 1;
      if (status_ff.busy === 1'b1) begin
         busy_len <= busy_len + 1;
         if (busy_len == 0) starts <= starts + 1;
      end else if (busy_len != 0) begin
         last_len <= busy_len;
         busy_len <= 0;
      end
      if (cycles == 40000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wren(input logic [7:0] op);
      i_host.frame({op, 32'h0}, 8, 1'b0);
   endtask
   task automatic rd_stat(input logic [7:0] exp);
      int e0;
      e0 = en_hits;
      i_host.frame({8'h05, 32'h0}, 8, 1'b1);
      check(rd_byte, exp);
      check(8'(en_hits != e0), 8'h01);
      check({7'h0, serial_out_en_ff}, 8'h00);
   endtask
   task automatic erase(input logic [31:0] a, input int extra);
      if (addr4_mode) i_host.frame({8'h44, a}, 40 + extra, 1'b0);
      else i_host.frame({8'h44, a[23:0], 8'h00}, 32 + extra, 1'b0);
      repeat (6) @(negedge clk_sys);
   endtask
   task automatic t_refused();
      logic [31:0] adr [9] = '{32'h1000, 32'h11000, 32'h1100, 32'h0, 32'h4000, 32'h2000, 32'h1000, 32'h1000,
         32'h1000};
      int r0;
      int s0;
      for (int k = 0; k < 9; k++) begin
         if (k != 0) wren(8'h06);
         region_otp_lock_bits = (k == 5) ? 3'h2 : 3'h0;
         quad_peripheral_mode = (k == 6);
         r0 = rejects;
         s0 = starts;
         erase(adr[k], (k == 7) ? 1 : (k == 8) ? -1 : 0);
         check(8'(starts - s0), 8'h00);
         check(8'(rejects - r0), 8'h01);
         quad_peripheral_mode = 1'b0;
         rd_stat({6'h0, k != 0, 1'b0});
      end
      // Clear request drops the latch when idle
      wren(8'h04);
      rd_stat(8'h00);
      $display("refusal cases done");
   endtask
   task automatic t_erase(input logic [3:0] rg, input logic a4);
      int r0;
      int s0;
      addr4_mode = a4;
      wren(8'h06);
      rd_stat(8'h02);
      if (a4) begin
         // Three-byte frame must be refused in four-byte mode
         r0 = rejects;
         s0 = starts;
         erase({16'h0, rg, 12'h0A5}, -8);
         check(8'(starts - s0), 8'h00);
         check(8'(rejects - r0), 8'h01);
      end
      r0 = rejects;
      erase({16'h0, rg, 4'h0, 8'hA5}, 0);
      check({5'h0, erase_region_ff}, 8'(1 << (rg - 1)));
      rd_stat(8'h03);
      wren(8'h04);
      rd_stat(8'h03);
      for (int w = 0; w < 2000 && status_ff.busy !== 1'b0; w++) @(negedge clk_sys);
      repeat (2) @(negedge clk_sys);
      check(8'(last_len), 8'(ERASE_CYC));
      check(8'(last_len >> 8), 8'(ERASE_CYC >> 8));
      check({5'h0, erase_region_ff}, 8'h00);
      check(8'(rejects - r0), 8'h00);
      rd_stat(8'h00);
      $display("erase of region %0d done", rg);
   endtask
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (4) @(negedge clk_sys);
      check({3'h0, status_ff, erase_region_ff}, 8'h00);
      $display("reset test done");
      t_refused();
      for (int r = 1; r <= 3; r++) t_erase(4'(r), 1'b0);
      t_erase(4'h2, 1'b1);
      complete_run();
   end
endmodule // test_soe_region_erase
